/* File: rtl/uasp_cfg.svh */
// Purpose: constants for the async serial port
// Assumes: 8-bit register port, byte-wide registers
// Notes: offsets are register-port addresses
`ifndef UASP_CFG_SVH
`define UASP_CFG_SVH
`define UASP_CTRL_ADDR  8'h98
`define UASP_DATA_ADDR  8'h99
`define UASP_CTRL_RESET 8'h40
`define UASP_DATA_RESET 8'h00
`define UASP_B_FMT      7
`define UASP_B_UNUSED   6
`define UASP_B_MCE      5
`define UASP_B_REN      4
`define UASP_B_TB8      3
`define UASP_B_RB8      2
`define UASP_B_TI       1
`define UASP_B_RI       0
`define UASP_TMR_MAX    8'hFF
`define UASP_CLK_NS     25
`endif

/* File: rtl/uasp_pkg.sv */
// Purpose: shared types of the async serial port
// Assumes: nothing
// Notes: state codes are binary
package uasp_pkg;
  typedef enum logic [1:0] {
    UASP_TX_IDLE  = 2'b00,
    UASP_TX_START = 2'b01,
    UASP_TX_DATA  = 2'b10,
    UASP_TX_STOP  = 2'b11
  } uasp_tx_e;
  typedef enum logic [1:0] {
    UASP_RX_IDLE  = 2'b00,
    UASP_RX_START = 2'b01,
    UASP_RX_DATA  = 2'b10,
    UASP_RX_STOP  = 2'b11
  } uasp_rx_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } uasp_req_s;
  typedef struct packed {
    logic overflow;
    logic tick;
    logic run;
    logic [7:0] reload;
  } uasp_baud_s;
endpackage

/* File: rtl/uasp_top.sv */
// Purpose: full-duplex async serial port, 8/9-bit frames
// Assumes: pins and baud inputs synchronous to CORE_CLK
// Notes on behaviour
// - control bit 7 selects 8 or 9-bit frame
// - 8-bit frame is ten bit times
// - bits shifted least significant first
// - 8-bit mode stores byte and stop bit
// - data write starts a transmission
// - transmit flag set at stop bit start
// - receiver works only while enabled
// - 8-bit accept needs clear flag, stop check
// - overrun keeps the old buffered byte
// - rejected frame changes nothing, no flag
// - interrupt request when either flag set
// - flags cleared only by software writes
// - 9-bit frame is eleven bit times
// - ninth transmit bit sent in 9-bit mode
// - 9-bit mode stores ninth bit, ignores stop
// - 9-bit accept needs flag clear, address check
// - receive flag set at stop sampling
// - address check passes only address bytes
// - control bit 6 reads one, ignores writes
// - data reads return receive buffer only
// - bit rate is half timer overflow rate
// - receive timer copy reloads on start edge
`include "uasp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module uasp_top (
  // clock and reset
  input  wire logic              CORE_CLK,
  input  wire logic              ARST_N,
  // register port
  input  wire uasp_pkg::uasp_req_s  REG_REQ,
  output var  logic [7:0]        REG_RDATA,
  // baud timer
  input  wire uasp_pkg::uasp_baud_s BAUD,
  // interrupt
  input  wire logic              IRQ_ENABLE,
  output logic                   SERIAL_IRQ,
  // line
  input  wire logic              SERIAL_IN,
  output var  logic              SERIAL_OUT
);
  import uasp_pkg::*;

  logic       frame_format_select;
  logic       address_stop_check_enable;
  logic       receiver_enable;
  logic       ninth_transmit_bit;
  logic       ninth_receive_bit;
  logic       transmit_done_flag;
  logic       receive_done_flag;
  logic [7:0] rx_buffer;

  uasp_tx_e   tx_st;
  logic [7:0] tx_sh;
  logic       tx_nine;
  logic [3:0] tx_cnt;
  logic       tx_half;
  logic       tx_bit;
  logic       set_ti;

  uasp_rx_e   rx_st;
  logic [7:0] rx_tmr;
  logic       rx_ovf;
  logic       rx_half;
  logic       rx_samp;
  logic       rx_prev;
  logic       start_edge;
  logic [8:0] rx_sh;
  logic [3:0] rx_cnt;
  logic       rx_done;
  logic       rx_accept;
  logic [7:0] rx_byte;
  logic       rx_qual;

  logic ctrl_wr;
  logic data_wr;
  logic ctrl_rd;
  logic data_rd;

  // number of data bits in the current frame
  function automatic logic [3:0] data_bits(input logic fmt);
    data_bits = fmt ? 4'h9 : 4'h8;
  endfunction

  assign ctrl_wr = REG_REQ.wr && (REG_REQ.addr == `UASP_CTRL_ADDR);
  assign data_wr = REG_REQ.wr && (REG_REQ.addr == `UASP_DATA_ADDR);
  assign ctrl_rd = REG_REQ.rd && (REG_REQ.addr == `UASP_CTRL_ADDR);
  assign data_rd = REG_REQ.rd && (REG_REQ.addr == `UASP_DATA_ADDR);

  // configuration bits written by software
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      frame_format_select       <= 1'b0;
      address_stop_check_enable <= 1'b0;
      receiver_enable           <= 1'b0;
      ninth_transmit_bit        <= 1'b0;
    end else if (ctrl_wr) begin
      frame_format_select       <= REG_REQ.wdata[`UASP_B_FMT];
      address_stop_check_enable <= REG_REQ.wdata[`UASP_B_MCE];
      receiver_enable           <= REG_REQ.wdata[`UASP_B_REN];
      ninth_transmit_bit        <= REG_REQ.wdata[`UASP_B_TB8];
    end
  end

  // status flags: hardware only sets, a write loads, set wins
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      transmit_done_flag <= 1'b0;
      receive_done_flag  <= 1'b0;
    end else begin
      if (set_ti)
        transmit_done_flag <= 1'b1;
      else if (ctrl_wr)
        transmit_done_flag <= REG_REQ.wdata[`UASP_B_TI];
      if (rx_accept)
        receive_done_flag <= 1'b1;
      else if (ctrl_wr)
        receive_done_flag <= REG_REQ.wdata[`UASP_B_RI];
    end
  end

  // receive buffer and ninth receive bit
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_buffer         <= `UASP_DATA_RESET;
      ninth_receive_bit <= 1'b0;
    end else if (rx_accept) begin
      rx_buffer         <= rx_byte;
      ninth_receive_bit <= rx_qual;
    end else if (ctrl_wr) begin
      ninth_receive_bit <= REG_REQ.wdata[`UASP_B_RB8];
    end
  end

  // read data stands one cycle after the strobe
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      REG_RDATA <= 8'h00;
    end else if (ctrl_rd) begin
      REG_RDATA <= {frame_format_select, 1'b1,
                    address_stop_check_enable, receiver_enable,
                    ninth_transmit_bit, ninth_receive_bit,
                    transmit_done_flag, receive_done_flag};
    end else if (data_rd) begin
      REG_RDATA <= rx_buffer;
    end else begin
      REG_RDATA <= 8'h00;
    end
  end

  assign SERIAL_IRQ = IRQ_ENABLE && (transmit_done_flag || receive_done_flag);

  // transmit bit clock: every second overflow
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N)
      tx_half <= 1'b0;
    else if (BAUD.overflow)
      tx_half <= ~tx_half;
  end
  assign tx_bit = BAUD.overflow && tx_half;

  // transmitter; a write while busy is ignored so a frame is never cut
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      tx_st      <= UASP_TX_IDLE;
      tx_sh      <= 8'h00;
      tx_nine    <= 1'b0;
      tx_cnt     <= 4'h0;
      SERIAL_OUT <= 1'b1;
    end else begin
      case (tx_st)
        UASP_TX_IDLE: begin
          SERIAL_OUT <= 1'b1;
          if (data_wr) begin
            tx_sh   <= REG_REQ.wdata;
            tx_nine <= ninth_transmit_bit;
            tx_cnt  <= 4'h0;
            tx_st   <= UASP_TX_START;
          end
        end
        UASP_TX_START: begin
          if (tx_bit) begin
            SERIAL_OUT <= 1'b0;
            tx_st      <= UASP_TX_DATA;
          end
        end
        UASP_TX_DATA: begin
          if (tx_bit) begin
            if (tx_cnt == data_bits(frame_format_select)) begin
              SERIAL_OUT <= 1'b1;
              tx_st      <= UASP_TX_STOP;
            end else begin
              SERIAL_OUT <= tx_sh[0];
              tx_sh      <= {tx_nine, tx_sh[7:1]};
              tx_cnt     <= tx_cnt + 4'h1;
            end
          end
        end
        UASP_TX_STOP: begin
          if (tx_bit)
            tx_st <= UASP_TX_IDLE;
        end
        default: tx_st <= UASP_TX_IDLE;
      endcase
    end
  end
  assign set_ti = tx_bit && (tx_st == UASP_TX_DATA) &&
                  (tx_cnt == data_bits(frame_format_select));

  // receive timer copy shares the reload value
  assign start_edge = receiver_enable && (rx_st == UASP_RX_IDLE) &&
                      rx_prev && !SERIAL_IN;
  assign rx_ovf = BAUD.run && BAUD.tick && (rx_tmr == `UASP_TMR_MAX);

  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_tmr  <= 8'h00;
      rx_half <= 1'b0;
      rx_prev <= 1'b1;
    end else begin
      rx_prev <= SERIAL_IN;
      if (start_edge) begin
        rx_tmr  <= BAUD.reload;
        rx_half <= 1'b0;
      end else if (BAUD.run && BAUD.tick) begin
        rx_tmr <= rx_ovf ? BAUD.reload : rx_tmr + 8'h01;
        if (rx_ovf)
          rx_half <= ~rx_half;
      end
    end
  end
  // reload spans half a bit, so the first and every second overflow after a start edge fall at bit centres
  assign rx_samp = rx_ovf && !rx_half;

  // receiver
  always_ff @(posedge CORE_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      rx_st  <= UASP_RX_IDLE;
      rx_sh  <= 9'h000;
      rx_cnt <= 4'h0;
    end else if (!receiver_enable) begin
      rx_st <= UASP_RX_IDLE;
    end else begin
      case (rx_st)
        UASP_RX_IDLE: begin
          if (start_edge)
            rx_st <= UASP_RX_START;
        end
        UASP_RX_START: begin
          // a high line at the centre is a glitch, not a start
          if (rx_samp) begin
            rx_st  <= SERIAL_IN ? UASP_RX_IDLE : UASP_RX_DATA;
            rx_cnt <= 4'h0;
          end
        end
        UASP_RX_DATA: begin
          if (rx_samp) begin
            rx_sh  <= {SERIAL_IN, rx_sh[8:1]};
            rx_cnt <= rx_cnt + 4'h1;
            if (rx_cnt == data_bits(frame_format_select) - 4'h1)
              rx_st <= UASP_RX_STOP;
          end
        end
        UASP_RX_STOP: begin
          if (rx_samp)
            rx_st <= UASP_RX_IDLE;
        end
        default: rx_st <= UASP_RX_IDLE;
      endcase
    end
  end

  assign rx_done = receiver_enable && rx_samp && (rx_st == UASP_RX_STOP);
  // 8-bit frames fill rx_sh[8:1]; 9-bit frames put the ninth bit in [8]
  assign rx_byte = frame_format_select ? rx_sh[7:0] : rx_sh[8:1];
  assign rx_qual = frame_format_select ? rx_sh[8] : SERIAL_IN;
  assign rx_accept = rx_done && !receive_done_flag &&
                     (!address_stop_check_enable || rx_qual);

  // checks

  property p_ctrl_bit6;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      ctrl_rd |=> REG_RDATA[`UASP_B_UNUSED];
  endproperty
  a_ctrl_bit6: assert property (p_ctrl_bit6) else $error("bit 6 read as zero");

  property p_data_read;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      data_rd |=> REG_RDATA == $past(rx_buffer);
  endproperty
  a_data_read: assert property (p_data_read) else $error("data read not rx buffer");

  property p_irq;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      (transmit_done_flag || receive_done_flag) && IRQ_ENABLE |-> SERIAL_IRQ;
  endproperty
  a_irq: assert property (p_irq) else $error("interrupt missing");

  property p_ti_sticky;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      transmit_done_flag && !ctrl_wr |=> transmit_done_flag;
  endproperty
  a_ti_sticky: assert property (p_ti_sticky) else $error("tx flag cleared by hw");

  property p_ri_sticky;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      receive_done_flag && !ctrl_wr |=> receive_done_flag;
  endproperty
  a_ri_sticky: assert property (p_ri_sticky) else $error("rx flag cleared by hw");

  property p_ti_at_stop;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      set_ti |=> tx_st == UASP_TX_STOP && SERIAL_OUT && transmit_done_flag;
  endproperty
  a_ti_at_stop: assert property (p_ti_at_stop) else $error("tx flag not at stop");

  property p_overrun;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      rx_done && receive_done_flag |=> $stable(rx_buffer);
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun overwrote buffer");

  property p_reject;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      rx_done && address_stop_check_enable && !rx_qual && !ctrl_wr
      |=> $stable(rx_buffer) && $stable(receive_done_flag) && $stable(ninth_receive_bit);
  endproperty
  a_reject: assert property (p_reject) else $error("rejected frame stored");

  property p_ren_off;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      !receiver_enable |=> rx_st == UASP_RX_IDLE;
  endproperty
  a_ren_off: assert property (p_ren_off) else $error("receiver ran disabled");

  property p_idle_high;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      tx_st == UASP_TX_START |-> SERIAL_OUT;
  endproperty
  a_idle_high: assert property (p_idle_high) else $error("line low before start");

  property p_start_reload;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      start_edge |=> rx_tmr == $past(BAUD.reload) && !rx_half;
  endproperty
  a_start_reload: assert property (p_start_reload) else $error("no reload on start");

  property p_rx_store;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      rx_accept |=> rx_buffer == $past(rx_byte) && receive_done_flag &&
                    ninth_receive_bit == $past(rx_qual);
  endproperty
  a_rx_store: assert property (p_rx_store) else $error("accepted frame not stored");

  property p_tx_load;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      data_wr && tx_st == UASP_TX_IDLE |=> tx_st == UASP_TX_START && tx_sh == $past(REG_REQ.wdata);
  endproperty
  a_tx_load: assert property (p_tx_load) else $error("data write did not start frame");

  property p_tx_lsb;
    @(posedge CORE_CLK) disable iff (!ARST_N)
      tx_bit && tx_st == UASP_TX_DATA && tx_cnt != data_bits(frame_format_select)
      |=> SERIAL_OUT == $past(tx_sh[0]);
  endproperty
  a_tx_lsb: assert property (p_tx_lsb) else $error("tx bit not lsb of shifter");

endmodule
`default_nettype wire

/* File: verification/uasp_peer.sv */
// Purpose: remote serial node on the far side of the port
// Assumes: bit period of BIT core cycles, both lines idle high
// Notes: stop bit of an 8-bit frame may be sent low on request
`timescale 1ns/1ps
`default_nettype none
module uasp_peer #(
  parameter int BIT = 8
) (
  // clock
  input  wire logic       clk,
  // line
  input  wire logic       nine_mode,
  input  wire logic       from_dut,
  output var  logic       to_dut,
  // captured frame
  output var  logic [7:0] rx_byte,
  output var  logic       rx_nine,
  output var  logic       rx_stop,
  output var  int         rx_count
);
  logic [9:0] sh;
  int         m;
  initial begin
    to_dut = 1'b1;
    rx_count = 0;
  end
  // q is the ninth bit in 9-bit frames, the stop level in 8-bit frames
  task automatic send(input logic [7:0] d, input logic q);
    logic [10:0] f;
    int          n;
    f = {1'b1, q, d, 1'b0};
    n = nine_mode ? 11 : 10;
    for (int i = 0; i < n; i++) begin
      to_dut <= f[i];
      repeat (BIT) @(posedge clk);
    end
    // a low stop bit must not leave the line low, or the next start has no edge
    to_dut <= 1'b1;
  endtask
  // samples at bit centres, half a bit after the falling start edge
  always begin
    @(negedge from_dut);
    repeat (BIT / 2) @(posedge clk);
    if (from_dut == 1'b0) begin
      m = nine_mode ? 10 : 9;
      for (int i = 0; i < m; i++) begin
        repeat (BIT) @(posedge clk);
        sh[i] = from_dut;
      end
      rx_byte = sh[7:0];
      rx_nine = sh[8];
      rx_stop = sh[m-1];
      rx_count++;
    end
  end
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: self-checking bench of the async serial port
// Assumes: overflow every 4 cycles, receive timer reload 0xFC, so one bit is 8 cycles
// Notes: rows hold {format, check, qualifier, accepted, data}
`include "uasp_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import uasp_pkg::*;
  logic       CORE_CLK;
  logic       ARST_N;
  uasp_req_s  req;
  logic [7:0] REG_RDATA;
  uasp_baud_s baud;
  logic       IRQ_ENABLE;
  logic       SERIAL_IRQ;
  logic       SERIAL_IN;
  logic       SERIAL_OUT;
  logic       nine;
  logic [7:0] p_byte;
  logic       p_nine;
  logic       p_stop;
  int         p_count;
  int         n_mismatch;
  int         compares;
  logic [1:0] bcnt;
  logic [11:0] r;
  logic [7:0] last;
  logic       rb8e;
  int         cnt0;
  int         k;
  localparam logic [11:0] ROWS [6] = '{12'h3A5, 12'h43C, 12'h15A, 12'hF81, 12'hC7E, 12'h942};

  uasp_top uasp_top_inst (
    .CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .REG_REQ(req), .REG_RDATA(REG_RDATA),
    .BAUD(baud), .IRQ_ENABLE(IRQ_ENABLE), .SERIAL_IRQ(SERIAL_IRQ),
    .SERIAL_IN(SERIAL_IN), .SERIAL_OUT(SERIAL_OUT)
  );
  uasp_peer #(.BIT(8)) uasp_peer_inst (
    .clk(CORE_CLK), .nine_mode(nine), .from_dut(SERIAL_OUT), .to_dut(SERIAL_IN),
    .rx_byte(p_byte), .rx_nine(p_nine), .rx_stop(p_stop), .rx_count(p_count)
  );

  initial begin
    CORE_CLK = 1'b0;
    forever #(`UASP_CLK_NS / 2.0) CORE_CLK = ~CORE_CLK;
  end
  // both timer overflows fall every fourth cycle
  always @(posedge CORE_CLK) begin
    bcnt <= bcnt + 2'd1;
    baud.overflow <= (bcnt == 2'd3);
  end

  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] v);
    compares++;
    if (v !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", nm, e, v);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge CORE_CLK);
    req.wr <= 1'b0;
    // one idle edge, so a following call never reassigns req in this time step
    @(posedge CORE_CLK);
  endtask
  task automatic rd_chk(input string nm, input logic [7:0] a, input logic [7:0] e);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge CORE_CLK);
    req.rd <= 1'b0;
    #1 chk(nm, e, REG_RDATA);
    @(posedge CORE_CLK);
  endtask
  task automatic complete_run();
    $display("compares %0d n_mismatch %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge CORE_CLK);
    n_mismatch++;
    complete_run();
  end

  initial begin
    n_mismatch = 0;
    compares = 0;
    bcnt = 2'd0;
    req = '0;
    baud = '{overflow: 1'b0, tick: 1'b1, run: 1'b1, reload: 8'hFC};
    IRQ_ENABLE = 1'b1;
    nine = 1'b0;
    ARST_N = 1'b0;
    repeat (20) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    @(posedge CORE_CLK);
    chk("idle line", 8'h01, {7'h00, SERIAL_OUT});
    rd_chk("ctrl reset", `UASP_CTRL_ADDR, `UASP_CTRL_RESET);
    rd_chk("data reset", `UASP_DATA_ADDR, `UASP_DATA_RESET);
    last = `UASP_DATA_RESET;
    for (int i = 0; i < 6; i++) begin
      r = ROWS[i];
      nine = r[11];
      // ninth rx bit preset to the inverse so a rejected frame shows it untouched
      wr(`UASP_CTRL_ADDR, {r[11], 1'b0, r[10], 1'b1, r[9], ~r[9], 2'b00});
      wr(`UASP_DATA_ADDR, r[7:0]);
      wr(`UASP_DATA_ADDR, 8'hFF);  // busy transmitter ignores it
      cnt0 = p_count;
      uasp_peer_inst.send(r[7:0], r[9]);
      k = 0;
      while (p_count == cnt0 && k < 200) begin
        @(posedge CORE_CLK);
        k++;
      end
      chk("peer frame", 8'h01, {7'h00, p_count != cnt0});
      rb8e = r[8] ? r[9] : ~r[9];
      rd_chk("ctrl", `UASP_CTRL_ADDR, {r[11], 1'b1, r[10], 1'b1, r[9], rb8e, 1'b1, r[8]});
      chk("irq", 8'h01, {7'h00, SERIAL_IRQ});
      if (r[8])
        last = r[7:0];
      rd_chk("rx data", `UASP_DATA_ADDR, last);
      chk("tx byte", r[7:0], p_byte);
      chk("tx tail", {6'h00, (r[11] ? r[9] : 1'b1), 1'b1}, {6'h00, p_nine, p_stop});
    end
    // receive flag still set from the last row: a new frame is an overrun
    uasp_peer_inst.send(8'hC3, 1'b1);
    rd_chk("overrun data", `UASP_DATA_ADDR, 8'h42);
    rd_chk("overrun ctrl", `UASP_CTRL_ADDR, 8'hD3);
    IRQ_ENABLE <= 1'b0;
    @(posedge CORE_CLK);
    #1 chk("irq masked", 8'h00, {7'h00, SERIAL_IRQ});
    IRQ_ENABLE <= 1'b1;
    wr(`UASP_CTRL_ADDR, 8'h00);
    nine = 1'b0;
    uasp_peer_inst.send(8'h99, 1'b1);
    rd_chk("disabled data", `UASP_DATA_ADDR, 8'h42);
    rd_chk("disabled ctrl", `UASP_CTRL_ADDR, 8'h40);
    chk("irq clear", 8'h00, {7'h00, SERIAL_IRQ});
    wr(8'h9A, 8'h55);
    rd_chk("unmapped", 8'h9A, 8'h00);
    // a reset in mid-run must bring back the reset values
    wr(`UASP_CTRL_ADDR, 8'hBF);
    rd_chk("ctrl preset", `UASP_CTRL_ADDR, 8'hFF);
    ARST_N <= 1'b0;
    repeat (2) @(posedge CORE_CLK);
    ARST_N <= 1'b1;
    @(posedge CORE_CLK);
    rd_chk("ctrl reset again", `UASP_CTRL_ADDR, `UASP_CTRL_RESET);
    rd_chk("data reset again", `UASP_DATA_ADDR, `UASP_DATA_RESET);
    complete_run();
  end
endmodule
`default_nettype wire
